//--- core/tpwm_timer.v
// triggered pwm / pulse width timer: one 16-bit counter, cycle register, three duty channels
// assumes classic wishbone master on clk_i; pins are asynchronous and synchronised here
// What this block does
// - run bit set outside mode 110: wait for trigger, idle
// - trigger: counter parked ffff jumps to zero
// - trigger while running restarts from zero
// - duty outputs go high on every trigger
// - channel zero output toggles, not pwm
// - period cycle plus one, width duty count
// - cycle match clears counter, raises interrupt
// - channel k interrupt on buffered compare match
// - buffers load at an armed cycle-match clear, or at a trigger from stop
// - trigger is pin edge or software bit
// - only channel-one write arms buffer reload
// - mode 110 measures, counts from run
// - capture edge stores count, clears counter
// - capture m raises interrupt m
// - event pin clocks counter in measurement too
// - run bit zero stops, one counts in mode 110 or after a trigger
`include "tpwm_consts.vh"
`timescale 1ns/1ns
module tpwm_timer #(
    parameter CW = 16
) (
    // clock and reset
    input  wire          clk_i,
    input  wire          rst_i,
    // wishbone slave
    input  wire          cyc_i,
    input  wire          stb_i,
    input  wire          we_i,
    input  wire [5:0]    adr_i,
    input  wire [3:0]    sel_i,
    input  wire [31:0]   dat_i,
    output reg  [31:0]   dat_o,
    output reg           ack_o,
    // pins
    input  wire          trig_pin_i,
    input  wire          event_clock_input_i,
    input  wire [3:0]    capture_input_i,
    output reg           toggle_output_zero_o,
    output reg  [3:1]    channel_pwm_output_o,
    // interrupt requests
    output reg           cycle_match_interrupt_o,
    output reg  [3:1]    channel_match_interrupt_o
);
    // software-visible registers and the compare buffers behind them
    reg  [7:0]    ctl0_r;
    reg  [7:0]    ctl1_r;
    reg  [7:0]    ioc1_r;
    reg  [1:0]    ioc2_r;
    reg  [CW-1:0] ccr_r [0:3];
    reg  [CW-1:0] buf_r [0:3];
    reg  [CW-1:0] cnt_r;
    reg           running_r;
    reg           reload_arm_r;
    reg           est_r;
    reg  [2:0]    pre_r;
    reg  [7:0]    div_r;
    // pin edge strobes, one clock each
    wire          trig_edge;
    wire          evt_edge;
    wire [3:0]    cap_edge;
    wire [3:0]    cap_sel_none;
    wire [3:1]    ch_hit;
    wire [3:1]    ch_done;
    wire [CW-1:0] cnt_inc;
    wire [CW-1:0] cap_val;
    reg  [31:0]   dat_nxt;

    wire       run        = ctl0_r[`TPWM_CTL0_RUN];
    wire [2:0] cks        = ctl0_r[`TPWM_CKS_HI:`TPWM_CKS_LO];
    wire       eee        = ctl1_r[`TPWM_CTL1_EEE];
    wire [2:0] mode       = ctl1_r[`TPWM_MD_HI:`TPWM_MD_LO];
    wire       meas       = (mode == `TPWM_MODE_PWM_MEAS);
    wire       trig_mode  = (mode == `TPWM_MODE_TRIG);
    wire       bus_req    = cyc_i && stb_i && !ack_o;
    wire       bus_wr     = bus_req && we_i;
    wire [3:0] widx       = adr_i[5:2];

    // edge detectors share one module; unused capture selects stay quiet
    tpwm_edge u_trig (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (trig_pin_i),
        .sel_i  (ioc2_r),
        .edge_o (trig_edge)
    );

    tpwm_edge u_evt (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (event_clock_input_i),
        .sel_i  (`TPWM_EDGE_RISE),
        .edge_o (evt_edge)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_cap
            tpwm_edge u_cap (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .pin_i  (capture_input_i[g]),
                .sel_i  (ioc1_r[2*g+1:2*g]),
                .edge_o (cap_edge[g])
            );
            assign cap_sel_none[g] = (ioc1_r[2*g+1:2*g] == `TPWM_EDGE_NONE);
        end
    endgenerate

    // count tick: event pin edges, or internal clock divided by 2^cks
    wire internal_tick = (cks == 3'h0) ? 1'b1 : (div_r == 8'h00);
    wire tick = run && (eee ? evt_edge : internal_tick);

    // software trigger pulse latched from write, consumed next cycle
    wire trigger = run && trig_mode && (trig_edge || est_r);
    wire cyc_match = running_r && tick && (cnt_r == buf_r[0]);
    wire [3:0] cap_hit = cap_edge & ~cap_sel_none;

    // capture keeps a tick that lands with the edge; an edge between ticks still counts
    assign cnt_inc = cnt_r + 16'h0001;
    assign cap_val = tick ? cnt_inc : cnt_r;

    // compare on the next count so each output changes on the count it names
    generate
        for (g = 1; g < 4; g = g + 1) begin : g_cmp
            assign ch_hit[g]  = (cnt_inc == buf_r[g]);
            assign ch_done[g] = (cnt_inc >= buf_r[g]);
        end
    endgenerate

    always @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= 3'h0;
            div_r <= 8'h00;
        end else begin
            // a changed select reloads at once instead of waiting out the old count
            pre_r <= cks;
            if (pre_r != cks || div_r == 8'h00) begin
                div_r <= (8'h01 << cks) - 8'h01;
            end else begin
                div_r <= div_r - 8'h01;
            end
        end
    end

    integer i;
    integer j;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctl0_r       <= `TPWM_RST_BYTE;
            ctl1_r       <= `TPWM_RST_BYTE;
            ioc1_r       <= `TPWM_RST_BYTE;
            ioc2_r       <= `TPWM_EDGE_NONE;
            est_r        <= 1'b0;
            reload_arm_r <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                ccr_r[i] <= `TPWM_RST_WORD;
                buf_r[i] <= `TPWM_RST_WORD;
            end
        end else begin
            // software trigger reads back zero; est_r holds the one-cycle pulse
            est_r <= 1'b0;
            if (bus_wr && sel_i[0]) begin
                case (widx)
                    `TPWM_ADR_CTL0: ctl0_r <= dat_i[7:0];
                    `TPWM_ADR_CTL1: begin
                        ctl1_r <= dat_i[7:0] & ~(8'h01 << `TPWM_CTL1_EST);
                        est_r  <= dat_i[`TPWM_CTL1_EST];
                    end
                    `TPWM_ADR_IOC1: ioc1_r <= dat_i[7:0];
                    `TPWM_ADR_IOC2: ioc2_r <= dat_i[1:0];
                    default: ;
                endcase
            end

            // ccr writes refused while measuring so captures are not overwritten
            if (bus_wr && widx >= `TPWM_ADR_CCR0 && widx <= `TPWM_ADR_CCR3 && !meas) begin
                if (sel_i[0]) ccr_r[widx[1:0]][7:0]  <= dat_i[7:0];
                if (sel_i[1]) ccr_r[widx[1:0]][15:8] <= dat_i[15:8];
            end

            // load wins over a new arm in the same cycle only if no new ch1 write
            if (cyc_match && reload_arm_r) begin
                for (i = 0; i < 4; i = i + 1) buf_r[i] <= ccr_r[i];
                reload_arm_r <= 1'b0;
            end
            if (bus_wr && widx == `TPWM_ADR_CCR1) reload_arm_r <= 1'b1;

            // a fresh start from stop copies the registers directly
            if (trigger && !running_r) begin
                for (i = 0; i < 4; i = i + 1) buf_r[i] <= ccr_r[i];
            end

            // every valid edge captures, whether or not a count tick falls with it
            if (meas && running_r) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (cap_hit[i]) ccr_r[i] <= cap_val;
                end
            end
        end
    end

    // counter, outputs and interrupt pulses
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r                     <= `TPWM_CNT_PARK;
            running_r                 <= 1'b0;
            toggle_output_zero_o      <= 1'b0;
            channel_pwm_output_o      <= 3'h0;
            cycle_match_interrupt_o   <= 1'b0;
            channel_match_interrupt_o <= 3'h0;
        end else begin
            cycle_match_interrupt_o   <= 1'b0;
            channel_match_interrupt_o <= 3'h0;
            // stopping parks the counter so the next trigger jumps from ffff
            if (!run) begin
                running_r            <= 1'b0;
                cnt_r                <= `TPWM_CNT_PARK;
                toggle_output_zero_o <= 1'b0;
                channel_pwm_output_o <= 3'h0;
            end else if (meas) begin
                running_r <= 1'b1;
                if (!running_r) begin
                    cnt_r <= `TPWM_CNT_ZERO;
                end else begin
                    if (|cap_hit) begin
                        cnt_r <= `TPWM_CNT_ZERO;
                    end else if (tick) begin
                        cnt_r <= cnt_inc;
                    end
                    cycle_match_interrupt_o   <= cap_hit[0];
                    channel_match_interrupt_o <= cap_hit[3:1];
                end
            end else if (trigger) begin
                // a retrigger mid-period restarts counter and outputs like the first one, but leaves the buffers unloaded
                running_r            <= 1'b1;
                cnt_r                <= `TPWM_CNT_ZERO;
                toggle_output_zero_o <= ~toggle_output_zero_o;
                channel_pwm_output_o <= 3'h7;
            end else if (running_r && tick) begin
                if (cyc_match) begin
                    cnt_r                   <= `TPWM_CNT_ZERO;
                    cycle_match_interrupt_o <= 1'b1;
                    toggle_output_zero_o    <= ~toggle_output_zero_o;
                    channel_pwm_output_o    <= 3'h7;
                end else begin
                    cnt_r <= cnt_inc;
                end

                // per channel: interrupt on the compare count, low from there on
                for (j = 1; j < 4; j = j + 1) begin
                    if (ch_hit[j] && !cyc_match) begin
                        channel_match_interrupt_o[j] <= 1'b1;
                    end
                    // width = duty counts: drop when next count reaches duty
                    if (!cyc_match && ch_done[j]) begin
                        channel_pwm_output_o[j] <= 1'b0;
                    end else if (cyc_match && buf_r[j] == `TPWM_RST_WORD) begin
                        // zero duty stays low through a period begun at cycle match; after a trigger it drops at the first tick
                        channel_pwm_output_o[j] <= 1'b0;
                    end
                end
            end
        end
    end

    // read mux kept combinational; the register below makes dat_o stand with ack
    always @* begin
        dat_nxt = 32'h0000_0000;
        case (widx)
            `TPWM_ADR_CTL0: dat_nxt = {24'h000000, ctl0_r};
            `TPWM_ADR_CTL1: dat_nxt = {24'h000000, ctl1_r};
            `TPWM_ADR_IOC1: dat_nxt = {24'h000000, ioc1_r};
            `TPWM_ADR_IOC2: dat_nxt = {30'h0, ioc2_r};
            `TPWM_ADR_CCR0: dat_nxt = {16'h0000, ccr_r[0]};
            `TPWM_ADR_CCR1: dat_nxt = {16'h0000, ccr_r[1]};
            `TPWM_ADR_CCR2: dat_nxt = {16'h0000, ccr_r[2]};
            `TPWM_ADR_CCR3: dat_nxt = {16'h0000, ccr_r[3]};
            `TPWM_ADR_CNT:  dat_nxt = {16'h0000, cnt_r};
            `TPWM_ADR_STAT: dat_nxt = {30'h0, reload_arm_r, running_r};
            default:        dat_nxt = 32'h0000_0000;
        endcase
    end

    // wishbone read and one-cycle ack
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            dat_o <= (bus_req && !we_i) ? dat_nxt : 32'h0000_0000;
        end
    end
endmodule // tpwm_timer

//--- inc/tpwm_consts.vh
// register offsets, field positions, reset values and mode codes for the trigger timer
// assumes a 32-bit wishbone slave with byte addresses; included by bare name
`ifndef TPWM_CONSTS_VH
`define TPWM_CONSTS_VH

`define TPWM_ADR_CTL0      4'h0
`define TPWM_ADR_CTL1      4'h1
`define TPWM_ADR_IOC1      4'h2
`define TPWM_ADR_IOC2      4'h3
`define TPWM_ADR_CCR0      4'h4
`define TPWM_ADR_CCR1      4'h5
`define TPWM_ADR_CCR2      4'h6
`define TPWM_ADR_CCR3      4'h7
`define TPWM_ADR_CNT       4'h8
`define TPWM_ADR_STAT      4'h9

`define TPWM_CTL0_RUN      7
`define TPWM_CKS_HI        2
`define TPWM_CKS_LO        0
`define TPWM_CTL1_EST      6
`define TPWM_CTL1_EEE      5
`define TPWM_MD_HI         2
`define TPWM_MD_LO         0
`define TPWM_MODE_TRIG     3'h2
`define TPWM_MODE_PWM_MEAS 3'h6

`define TPWM_EDGE_NONE     2'h0
`define TPWM_EDGE_RISE     2'h1
`define TPWM_EDGE_FALL     2'h2
`define TPWM_EDGE_BOTH     2'h3

`define TPWM_CNT_PARK      16'hffff
`define TPWM_CNT_ZERO      16'h0000
`define TPWM_RST_BYTE      8'h00
`define TPWM_RST_WORD      16'h0000

`endif

//--- core/tpwm_edge.v
// edge detector with two-flop synchroniser for one external pin
// assumes pin is asynchronous to clk_i; sel encodes none/rise/fall/both
`include "tpwm_consts.vh"
`timescale 1ns/1ns
module tpwm_edge (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // pin and edge select
    input  wire       pin_i,
    input  wire [1:0] sel_i,
    // detected edge, one cycle
    output wire       edge_o
);
    reg sync1_r;
    reg sync2_r;
    reg last_r;

    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            last_r  <= 1'b0;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            last_r  <= sync2_r;
        end
    end

    assign edge_o = ((sel_i == `TPWM_EDGE_RISE || sel_i == `TPWM_EDGE_BOTH) && sync2_r && !last_r) ||
                    ((sel_i == `TPWM_EDGE_FALL || sel_i == `TPWM_EDGE_BOTH) && !sync2_r && last_r);
endmodule // tpwm_edge

//--- tb/tpwm_timer_assertions.sv
// checker for tpwm_timer: bus handshake, read widths, interrupt pulses
// assumes a bind to tpwm_timer ports, one clock, synchronous reset
`timescale 1ns/1ns
module tpwm_timer_assertions #(parameter CW = 16) (
    // ports grouped by kind to stay compact
    input wire        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire [5:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i, dat_o,
    input wire        trig_pin_i, event_clock_input_i,
    input wire [3:0]  capture_input_i,
    input wire        toggle_output_zero_o, cycle_match_interrupt_o,
    input wire [3:1]  channel_pwm_output_o, channel_match_interrupt_o
);
    reg  run_r;
    wire rd_ack = ack_o && !we_i;
    // shadow of the run bit; lags the design by one edge, hence the 4-cycle margin
    always @(posedge clk_i) begin
        if (rst_i) run_r <= 1'b0;
        else if (cyc_i && stb_i && we_i && ack_o && adr_i[5:2] == 4'h0 && sel_i[0]) run_r <= dat_i[7];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
    chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    chk_unmapped_zero: assert property (rd_ack && adr_i[5:2] > 4'h9 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_ctl_width: assert property (rd_ack && adr_i[5:2] < 4'h4 |-> dat_o[31:8] == 24'h0)
        else $error("control read upper bits set");
    chk_ccr_width: assert property (rd_ack && adr_i[5:4] == 2'h1 |-> dat_o[31:16] == 16'h0)
        else $error("compare read upper half set");
    chk_cycle_pulse: assert property (cycle_match_interrupt_o |=> !cycle_match_interrupt_o)
        else $error("cycle interrupt too long");
    chk_chan_pulse: assert property ((channel_match_interrupt_o & $past(channel_match_interrupt_o)) == 3'h0)
        else $error("channel interrupt too long");
    chk_stop_quiet: assert property ((!run_r) [*4] |-> !cycle_match_interrupt_o && channel_match_interrupt_o == 3'h0)
        else $error("interrupt while stopped");
    cov_cycle: cover property (cycle_match_interrupt_o);
    cov_chan: cover property (channel_match_interrupt_o == 3'h4);
    cov_trig: cover property ($rose(trig_pin_i));
endmodule // tpwm_timer_assertions

//--- tb/tpwm_pins_model.sv
// far-side pin model: trigger pin, capture pins and event clock
// assumes clk_i is the timer clock; pins move by nba after a rising edge
`timescale 1ns/1ns
module tpwm_pins_model (
    // clock
    input  wire        clk_i,
    // pins toward the timer
    output logic       trig_pin_o,
    output logic       event_clock_o,
    output logic [3:0] capture_o
);
    initial begin
        trig_pin_o = 1'b0;
        event_clock_o = 1'b0;
        capture_o = 4'h0;
    end
    // held three clocks so the synchroniser cannot miss it
    task automatic trig_pulse();
        @(posedge clk_i);
        trig_pin_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        trig_pin_o <= 1'b0;
    endtask
    // n rising edges on one pin, gap clocks apart; event clock stands still unless ev_half > 0
    task automatic capture_train(input int pin, input int gap, input int ev_half, input int n);
        for (int i = 0; i < n * gap; i++) begin
            @(posedge clk_i);
            capture_o[pin] <= (i % gap) < 2;
            if (ev_half > 0 && i % ev_half == 0) event_clock_o <= ~event_clock_o;
        end
    endtask
endmodule // tpwm_pins_model

//--- tb/tpwm_timer_tb.sv
// bench for tpwm_timer: wishbone tasks, pin model, period and capture checks
// assumes the bench is the only bus master and the pin model drives every pin
`timescale 1ns/1ns
`include "tpwm_consts.vh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tpwm_timer_tb;
    reg         clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    reg  [5:0]  adr = 6'h0;
    reg  [3:0]  sel = 4'hf;
    reg  [31:0] wdat = 32'h0, rv, saved;
    reg         tz;
    wire [31:0] rdat;
    wire        ack, trig, evc, tog0, cmi;
    wire [3:0]  cap;
    wire [3:1]  pwm, cmk;
    int         checked = 0, fails = 0, cycles = 0, ncmi = 0, n0, span, tg, hi [1:3], ci [1:3];
    tpwm_timer dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .trig_pin_i(trig), .event_clock_input_i(evc),
        .capture_input_i(cap), .toggle_output_zero_o(tog0), .channel_pwm_output_o(pwm),
        .cycle_match_interrupt_o(cmi), .channel_match_interrupt_o(cmk));
    tpwm_pins_model pins (.clk_i(clk), .trig_pin_o(trig), .event_clock_o(evc), .capture_o(cap));
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cmi === 1'b1) ncmi++;
        if (cycles == 6000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] idx, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rv = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d); wb(1'b1, idx, d); endtask
    task automatic rd(input logic [3:0] idx); wb(1'b0, idx, 32'h0); endtask
    // one full period between two cycle-match pulses
    task automatic measure();
        logic t0;
        while (cmi !== 1'b1) @(posedge clk);
        t0 = tog0;
        span = 0;
        tg = 0;
        for (int k = 1; k <= 3; k++) begin
            hi[k] = 0;
            ci[k] = 0;
        end
        do begin
            @(posedge clk);
            span++;
            tg += (tog0 !== t0);
            t0 = tog0;
            for (int k = 1; k <= 3; k++) begin
                hi[k] += pwm[k];
                ci[k] += cmk[k];
            end
        end while (cmi !== 1'b1);
    endtask
    task automatic expect_period(input int d2);
        measure();
        `CHK(span, 20)
        `CHK(hi[1], 3)
        `CHK(hi[2], d2)
        `CHK(hi[3], 7)
        `CHK(tg, 1)
        for (int k = 1; k <= 3; k++) `CHK(ci[k], 1)
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`TPWM_ADR_CTL0);
        `CHK(rv, 32'h0)
        rd(`TPWM_ADR_CNT);
        `CHK(rv, 32'h0000ffff)
        wr(4'hf, 32'hffffffff);
        rd(4'hf);
        `CHK(rv, 32'h0)
        wr(`TPWM_ADR_CCR0, 32'd19);
        wr(`TPWM_ADR_CCR2, 32'd5);
        wr(`TPWM_ADR_CCR3, 32'd7);
        wr(`TPWM_ADR_CCR1, 32'd3);
        wr(`TPWM_ADR_IOC2, 32'h1);
        wr(`TPWM_ADR_CTL1, 32'h2);
        wr(`TPWM_ADR_CTL0, 32'h80);
        repeat (20) @(posedge clk);
        rd(`TPWM_ADR_CNT);
        `CHK(rv, 32'h0000ffff)
        wr(`TPWM_ADR_CTL1, 32'h42);
        expect_period(5);
        wr(`TPWM_ADR_CCR2, 32'd2);
        expect_period(5);
        wr(`TPWM_ADR_CCR1, 32'd3);
        measure();
        expect_period(2);
        fork
            pins.trig_pulse();
            begin
                // the trigger toggles output zero; all duty outputs must be high then
                tz = tog0;
                while (tog0 === tz) @(posedge clk);
                `CHK(pwm, 3'h7)
                span = 0;
                do begin
                    @(posedge clk);
                    span++;
                end while (cmi !== 1'b1);
                `CHK(span, 20)
            end
        join
        wr(`TPWM_ADR_CTL0, 32'h0);
        rd(`TPWM_ADR_CNT);
        saved = rv;
        repeat (5) @(posedge clk);
        rd(`TPWM_ADR_CNT);
        `CHK(rv, saved)
        wr(`TPWM_ADR_IOC1, 32'h1);
        wr(`TPWM_ADR_CTL1, 32'h6);
        wr(`TPWM_ADR_CTL0, 32'h80);
        n0 = ncmi;
        pins.capture_train(0, 20, 0, 3);
        `CHK(ncmi - n0, 3)
        rd(`TPWM_ADR_CCR0);
        `CHK(rv, 32'd20)
        wr(`TPWM_ADR_CTL0, 32'h0);
        wr(`TPWM_ADR_CTL1, 32'h26);
        wr(`TPWM_ADR_CTL0, 32'h87);
        pins.capture_train(0, 40, 2, 3);
        rd(`TPWM_ADR_CCR0);
        `CHK(rv, 32'd10)
        tally_and_finish();
    end
endmodule // tpwm_timer_tb
bind tpwm_timer tpwm_timer_assertions #(.CW(CW)) chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .trig_pin_i(trig_pin_i), .event_clock_input_i(event_clock_input_i), .capture_input_i(capture_input_i),
    .toggle_output_zero_o(toggle_output_zero_o), .cycle_match_interrupt_o(cycle_match_interrupt_o),
    .channel_pwm_output_o(channel_pwm_output_o), .channel_match_interrupt_o(channel_match_interrupt_o));
